// *** line_term_pkg.sv ***
// Function
// [R1] amplitude scale resets 110110, 2% per step
// [R2] software writes 110110 when no scaling wanted
// [R3] templates: 16 samples, four UIs, 7-bit codes
// [R4] transmit termination bit 2 selects internal/external
// [R5] software never selects external termination in T1/J1
// [R6] software pairs termination and template codes
// [R7] global pin or channel bit tristates outputs
// [R8] lost master clock tristates every channel
// [R9] lost transmit clock tristates, loopback/pattern excepted
// [R10] outputs held tristate after any reset
// [R11] transmit power down tristates that channel
// [R12] receive termination bit 2 selects internal/external
// [R13] software chooses receive termination code per standard
// [R14] activity monitors flag and release clock loss
// [R15] any single tristate condition disables driver
package line_term_pkg;

  // register indices; byte address is four times the index, channel in haddr[9:8]
  localparam logic [5:0] IDX_TX_CONFIG_A   = 6'h02;
  localparam logic [5:0] IDX_TX_CONFIG_B   = 6'h03;
  localparam logic [5:0] IDX_TERMINATION   = 6'h1A;
  localparam logic [5:0] IDX_AMP_SCALE     = 6'h20;
  localparam logic [5:0] IDX_LINE_STATUS   = 6'h21;
  localparam logic [5:0] IDX_SOFT_RESET    = 6'h22;

  // field positions
  localparam int CFGA_PWRDN_BIT   = 0;
  localparam int CFGA_RLOOP_BIT   = 1;
  localparam int CFGA_IPAT_BIT    = 2;
  localparam int CFGB_TRI_BIT     = 4;
  localparam int TERM_TX_EXT_BIT  = 2;
  localparam int TERM_RX_LSB      = 3;
  localparam int TERM_RX_EXT_BIT  = 5;

  // values after reset
  localparam logic [7:0] TX_CONFIG_A_RST = 8'h00;
  localparam logic [7:0] TX_CONFIG_B_RST = 8'h00;
  localparam logic [7:0] TERMINATION_RST = 8'h00;
  localparam logic [5:0] AMP_SCALE_RST   = 6'h36;
  localparam int         AMP_STEP_PCT    = 2;

  // timing at the core clock rate
  localparam int CLK_MHZ        = 40;
  localparam int LOSS_WINDOW_NS = 1000;
  localparam int RST_HOLD_NS    = 2000;
  localparam int LOSS_CYC       = (LOSS_WINDOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_HOLD_CYC   = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;

  // first-UI sample codes for templates 3..7 (T1 longer cables, then J1)
  localparam logic [6:0] TPL_UI1 [5][16] = '{
    '{7'h1B, 7'h2E, 7'h2C, 7'h2A, 7'h29, 7'h28, 7'h27, 7'h26,
      7'h25, 7'h50, 7'h4F, 7'h4D, 7'h4A, 7'h48, 7'h46, 7'h44},
    '{7'h1F, 7'h34, 7'h2F, 7'h2C, 7'h2B, 7'h2A, 7'h29, 7'h28,
      7'h25, 7'h57, 7'h53, 7'h50, 7'h4B, 7'h48, 7'h46, 7'h44},
    '{7'h20, 7'h3B, 7'h35, 7'h2F, 7'h2E, 7'h2D, 7'h2C, 7'h2A,
      7'h28, 7'h58, 7'h58, 7'h53, 7'h4C, 7'h48, 7'h46, 7'h44},
    '{7'h20, 7'h3F, 7'h38, 7'h33, 7'h2F, 7'h2E, 7'h2D, 7'h2C,
      7'h29, 7'h5F, 7'h5E, 7'h57, 7'h4F, 7'h49, 7'h47, 7'h44},
    '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24,
      7'h23, 7'h4A, 7'h4A, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43}
  };
  localparam logic [3:0] TPL_FIRST_TABLE = 4'h3;
  localparam logic [3:0] TPL_J1          = 4'h7;

endpackage : line_term_pkg

// *** line_termination_driver_control.sv ***
// line driver enable, termination select and pulse template control, AHB-Lite slave
module line_termination_driver_control #(
  parameter int NUM_CH = 4
) (
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  mclk_in,
  input  wire logic [NUM_CH-1:0]     tx_clock_in,
  input  wire logic                  line_driver_tristate,
  input  wire logic [1:0]            wave_ui,
  input  wire logic [3:0]            wave_sample,
  output logic      [NUM_CH-1:0]     tx_line_oe,
  output logic      [NUM_CH-1:0]     tx_path_powered_down,
  output logic      [NUM_CH-1:0]     tx_term_external,
  output logic      [2*NUM_CH-1:0]   tx_term_ohm_sel,
  output logic      [NUM_CH-1:0]     rx_term_external,
  output logic      [2*NUM_CH-1:0]   rx_term_ohm_sel,
  output logic      [6*NUM_CH-1:0]   amplitude_scale,
  output logic      [4*NUM_CH-1:0]   pulse_template_select,
  output logic      [7*NUM_CH-1:0]   wave_code
);
  import line_term_pkg::*;

  localparam int LW = $clog2(LOSS_CYC + 1);
  localparam int HW = $clog2(RST_HOLD_CYC + 1);
  localparam logic [LW-1:0] LOSS_LIM = LW'(LOSS_CYC);
  localparam logic [HW-1:0] HOLD_LIM = HW'(RST_HOLD_CYC);

  // monitor index NUM_CH watches the master clock, the others the transmit clocks
  typedef struct packed {
    logic [NUM_CH:0]               sync_a;
    logic [NUM_CH:0]               sync_b;
    logic [NUM_CH:0]               sync_c;
    logic [NUM_CH:0][LW-1:0]       idle_cnt;
    logic [NUM_CH:0]               lost;
    logic [1:0]                    tri_sync;
    logic [NUM_CH-1:0][7:0]        cfga;
    logic [NUM_CH-1:0][7:0]        cfgb;
    logic [NUM_CH-1:0][7:0]        term;
    logic [NUM_CH-1:0][5:0]        amp;
    logic [NUM_CH-1:0][6:0]        wave;
    logic [NUM_CH-1:0]             oe;
    logic [HW-1:0]                 hold_cnt;
    logic                          pend;
    logic                          pwrite;
    logic [1:0]                    pch;
    logic [5:0]                    pidx;
    logic                          rdy;
    logic [31:0]                   rdata;
  } state_s;

  state_s          st_ff;
  state_s          nxt_st;
  logic [NUM_CH-1:0] hz_ch;

  // template lookup; tables 0..2 and UIs 2..3 read as zero code, UI 1 holds codes only in its first samples
  function automatic logic [6:0] tpl_code(input logic [3:0] tpl, input logic [1:0] ui, input logic [3:0] smp);
    logic [6:0] code;
    logic [3:0] row;
    code = 7'h00;
    row  = tpl - TPL_FIRST_TABLE;
    if (tpl >= TPL_FIRST_TABLE && tpl <= TPL_J1) begin
      if (ui == 2'h0) begin
        code = TPL_UI1[row[2:0]][smp];
      end else if (ui == 2'h1) begin
        if (tpl == TPL_J1) begin
          code = (smp == 4'h0) ? 7'h42 : ((smp == 4'h1) ? 7'h41 : 7'h00);
        end else begin
          code = (smp == 4'h0) ? 7'h43 : ((smp == 4'h1) ? 7'h42 : ((smp == 4'h2) ? 7'h41 : 7'h00));
        end
      end
    end
    return code;
  endfunction : tpl_code

  // tristate conditions per channel, any one alone suffices
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      hz_ch[c] = st_ff.tri_sync[1]                                       // [R7]
               | st_ff.cfgb[c][CFGB_TRI_BIT]                             // [R7]
               | st_ff.lost[NUM_CH]                                      // [R8]
               | (st_ff.lost[c] & ~st_ff.cfga[c][CFGA_RLOOP_BIT]
                  & ~st_ff.cfga[c][CFGA_IPAT_BIT])                       // [R9]
               | st_ff.cfga[c][CFGA_PWRDN_BIT]                           // [R11]
               | (st_ff.hold_cnt != '0);                                 // [R10] [R15]
    end
  end

  // next state: monitors, pin sync, bus slave, configuration, line outputs
  always_comb begin
    nxt_st = st_ff;
    // clock activity monitors; third stage only remembers the previous sample
    nxt_st.sync_a = {mclk_in, tx_clock_in};
    nxt_st.sync_b = st_ff.sync_a;
    nxt_st.sync_c = st_ff.sync_b;
    for (int m = 0; m <= NUM_CH; m++) begin
      if (st_ff.sync_b[m] != st_ff.sync_c[m]) begin
        nxt_st.idle_cnt[m] = '0;                                         // [R14]
        nxt_st.lost[m]     = 1'b0;
      end else if (st_ff.idle_cnt[m] == LOSS_LIM) begin
        nxt_st.lost[m]     = 1'b1;                                       // [R14]
      end else begin
        nxt_st.idle_cnt[m] = st_ff.idle_cnt[m] + 1'b1;
      end
    end
    nxt_st.tri_sync = {st_ff.tri_sync[0], line_driver_tristate};
    if (st_ff.hold_cnt != '0) begin
      nxt_st.hold_cnt = st_ff.hold_cnt - 1'b1;
    end
    // bus: one wait state so read data leaves a flip-flop
    nxt_st.rdy = 1'b1;
    if (st_ff.pend) begin
      nxt_st.pend = 1'b0;
      nxt_st.rdata = 32'h0000_0000;
      for (int c = 0; c < NUM_CH; c++) begin
        if (st_ff.pch == 2'(c)) begin
          case (st_ff.pidx)
            IDX_TX_CONFIG_A: begin
              nxt_st.rdata[7:0] = st_ff.cfga[c];
              if (st_ff.pwrite) nxt_st.cfga[c] = hwdata[7:0];
            end
            IDX_TX_CONFIG_B: begin
              nxt_st.rdata[7:0] = st_ff.cfgb[c];
              if (st_ff.pwrite) nxt_st.cfgb[c] = hwdata[7:0];
            end
            IDX_TERMINATION: begin
              nxt_st.rdata[7:0] = st_ff.term[c];
              if (st_ff.pwrite) nxt_st.term[c] = hwdata[7:0];               // [R4] [R12]
            end
            IDX_AMP_SCALE: begin
              nxt_st.rdata[5:0] = st_ff.amp[c];
              if (st_ff.pwrite) nxt_st.amp[c] = hwdata[5:0];                // [R1]
            end
            IDX_LINE_STATUS: begin
              nxt_st.rdata[3:0] = {st_ff.hold_cnt != '0, st_ff.oe[c], st_ff.lost[c], st_ff.lost[NUM_CH]};
            end
            default: begin
              nxt_st.rdata = 32'h0000_0000;
            end
          endcase
        end
      end
      // soft reset restores configuration and restarts the hold window
      if (st_ff.pwrite && st_ff.pidx == IDX_SOFT_RESET && hwdata[0]) begin
        for (int c = 0; c < NUM_CH; c++) begin
          nxt_st.cfga[c] = TX_CONFIG_A_RST;
          nxt_st.cfgb[c] = TX_CONFIG_B_RST;
          nxt_st.term[c] = TERMINATION_RST;
          nxt_st.amp[c]  = AMP_SCALE_RST;                                // [R1]
        end
        nxt_st.hold_cnt = HOLD_LIM;                                      // [R10]
      end
    end else if (hsel && htrans[1] && hready) begin
      nxt_st.pend   = 1'b1;
      nxt_st.pwrite = hwrite;
      nxt_st.pch    = haddr[9:8];
      nxt_st.pidx   = haddr[7:2];
      nxt_st.rdy    = 1'b0;
    end
    // line side outputs, registered
    for (int c = 0; c < NUM_CH; c++) begin
      nxt_st.oe[c]   = ~hz_ch[c];                                        // [R15]
      nxt_st.wave[c] = tpl_code(st_ff.cfgb[c][3:0], wave_ui, wave_sample); // [R3]
    end
    // pin reset: drivers off, config to defaults, hold window armed
    if (srst) begin
      nxt_st          = '0;
      nxt_st.rdy      = 1'b1;
      nxt_st.hold_cnt = HOLD_LIM;                                        // [R10]
      for (int c = 0; c < NUM_CH; c++) begin
        nxt_st.cfga[c] = TX_CONFIG_A_RST;
        nxt_st.cfgb[c] = TX_CONFIG_B_RST;
        nxt_st.term[c] = TERMINATION_RST;
        nxt_st.amp[c]  = AMP_SCALE_RST;                                  // [R1]
      end
    end
  end

  // single state register
  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end

  // outputs straight from the state register, hresp tied to okay
  assign hrdata    = st_ff.rdata;
  assign hreadyout = st_ff.rdy;
  assign hresp     = 1'b0;
  assign tx_line_oe = st_ff.oe;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      tx_path_powered_down[c]    = st_ff.cfga[c][CFGA_PWRDN_BIT];        // [R11]
      tx_term_external[c]        = st_ff.term[c][TERM_TX_EXT_BIT];       // [R4]
      tx_term_ohm_sel[2*c +: 2]  = st_ff.term[c][1:0];
      rx_term_external[c]        = st_ff.term[c][TERM_RX_EXT_BIT];       // [R12]
      rx_term_ohm_sel[2*c +: 2]  = st_ff.term[c][TERM_RX_LSB +: 2];
      amplitude_scale[6*c +: 6]  = st_ff.amp[c];
      pulse_template_select[4*c +: 4] = st_ff.cfgb[c][3:0];
      wave_code[7*c +: 7]        = st_ff.wave[c];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  amp_reset_a: assert property (                                          // [R1]
    $past(srst) |-> amplitude_scale[5:0] == AMP_SCALE_RST)
    else $error("amplitude scale not at reset value after reset");

  wave_table_a: assert property (                                         // [R3]
    $past(st_ff.cfgb[0][3:0]) == TPL_J1 && $past(wave_ui) == 2'h0 && $past(wave_sample) == 4'hF
      |-> wave_code[6:0] == 7'h43)
    else $error("template code mismatch");

  tx_term_a: assert property (                                            // [R4]
    st_ff.pend && st_ff.pwrite && st_ff.pidx == IDX_TERMINATION && st_ff.pch == 2'h0
      |=> tx_term_external[0] == $past(hwdata[2]) && tx_term_ohm_sel[1:0] == $past(hwdata[1:0]))
    else $error("transmit termination not taken from write");

  global_tri_a: assert property (                                         // [R7]
    $rose(line_driver_tristate) |-> ##4 tx_line_oe == '0)
    else $error("global tristate pin did not disable drivers");

  chan_tri_a: assert property (                                           // [R7]
    st_ff.cfgb[0][CFGB_TRI_BIT] |=> !tx_line_oe[0])
    else $error("channel tristate bit ignored");

  mclk_loss_a: assert property (                                          // [R8]
    st_ff.lost[NUM_CH] |=> tx_line_oe == '0)
    else $error("master clock loss did not tristate all");

  txclk_loss_a: assert property (                                         // [R9]
    st_ff.lost[0] && !st_ff.cfga[0][CFGA_RLOOP_BIT] && !st_ff.cfga[0][CFGA_IPAT_BIT] |=> !tx_line_oe[0])
    else $error("transmit clock loss did not tristate");

  reset_hold_a: assert property (                                         // [R10]
    $fell(srst) |-> (tx_line_oe == '0) [*8])
    else $error("drivers enabled too soon after reset");

  pwrdn_tri_a: assert property (                                          // [R11]
    st_ff.cfga[0][CFGA_PWRDN_BIT] |=> !tx_line_oe[0] && tx_path_powered_down[0])
    else $error("power down did not tristate");

  rx_term_a: assert property (                                            // [R12]
    st_ff.pend && st_ff.pwrite && st_ff.pidx == IDX_TERMINATION && st_ff.pch == 2'h0
      |=> rx_term_external[0] == $past(hwdata[5]))
    else $error("receive termination not taken from write");

  loss_window_a: assert property (                                        // [R14]
    $rose(st_ff.lost[NUM_CH]) |-> st_ff.idle_cnt[NUM_CH] == LOSS_LIM)
    else $error("loss flagged before full idle window");

  all_clear_a: assert property (                                          // [R15]
    !hz_ch[0] |=> tx_line_oe[0])
    else $error("driver off with no tristate condition");

endmodule : line_termination_driver_control

// *** line_termination_driver_control_tb.sv ***
// self-checking bench for the line termination and driver control block
module line_termination_driver_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import line_term_pkg::*;

  logic              core_clk = 0, srst = 1, hsel = 0, hwrite = 0, mclk_in = 0;
  logic              line_driver_tristate = 0, mclk_run = 1;
  logic              hready, hreadyout, hresp;
  logic [31:0]       haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]        htrans = 0, wave_ui = 0;
  logic [2:0]        hsize = 3'h2;
  logic [3:0]        wave_sample = 0, tx_clock_in = 0, tx_run = 4'hF;
  logic [3:0]        tx_line_oe, tx_path_powered_down, tx_term_external, rx_term_external;
  logic [7:0]        tx_term_ohm_sel, rx_term_ohm_sel;
  logic [23:0]       amplitude_scale;
  logic [15:0]       pulse_template_select;
  logic [27:0]       wave_code;
  int                err_total = 0, num_checks = 0, cyc = 0;

  // line clocks run off odd periods so they line up with a core clock edge only every 925 and 1075 ns
  always #12.5 core_clk = ~core_clk;
  always #37 mclk_in = mclk_in ^ mclk_run;
  always #43 tx_clock_in = tx_clock_in ^ tx_run;
  assign hready = hreadyout;

  line_termination_driver_control #(.NUM_CH(4)) u_dut (
    .core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mclk_in(mclk_in), .tx_clock_in(tx_clock_in),
    .line_driver_tristate(line_driver_tristate), .wave_ui(wave_ui), .wave_sample(wave_sample),
    .tx_line_oe(tx_line_oe), .tx_path_powered_down(tx_path_powered_down),
    .tx_term_external(tx_term_external), .tx_term_ohm_sel(tx_term_ohm_sel),
    .rx_term_external(rx_term_external), .rx_term_ohm_sel(rx_term_ohm_sel),
    .amplitude_scale(amplitude_scale), .pulse_template_select(pulse_template_select),
    .wave_code(wave_code));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // one single-word transfer; request held until hready is seen high at an edge
  task automatic bus(input logic [1:0] ch, input logic [5:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, ch, idx, 2'h0};
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [1:0] ch, input logic [5:0] idx, input logic [31:0] d);
    bus(ch, idx, 1'b1, d);
  endtask : wr

  task automatic rdchk(input logic [1:0] ch, input logic [5:0] idx, input logic [31:0] exp, input string msg);
    bus(ch, idx, 1'b0, 32'h0);
    chk(rd, exp, msg);
  endtask : rdchk

  task automatic t_reset();
    chk(tx_line_oe, 4'h0, "oe at release");
    chk(hresp, 1'b0, "okay response");
    for (int c = 0; c < 4; c++) begin
      chk(amplitude_scale[6*c +: 6], 6'h36, "scale out");
      rdchk(c[1:0], IDX_AMP_SCALE, 32'h36, "scale reg");
      rdchk(c[1:0], IDX_TX_CONFIG_B, 32'h0, "cfg b reg");
    end
    chk(tx_line_oe, 4'h0, "oe in hold");
    repeat (100) @(posedge core_clk);
    chk(tx_line_oe, 4'hF, "oe after hold");
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    wr(0, IDX_AMP_SCALE, 32'h37);
    chk(amplitude_scale[5:0], 6'h37, "scale step");
    rdchk(0, IDX_AMP_SCALE, 32'h37, "scale read");
    wr(0, IDX_AMP_SCALE, 32'h36);
    chk(amplitude_scale[5:0], 6'h36, "scale unscaled");
    // channel 0 termination so the write-path assertions see a transfer
    wr(0, IDX_TERMINATION, 32'h2A);
    chk(tx_term_ohm_sel[1:0], 2'h2, "ch0 tx ohm");
    chk(rx_term_external[0], 1'b1, "ch0 rx ext");
    wr(0, 6'h10, 32'hFF);
    rdchk(0, 6'h10, 32'h0, "unmapped");
    for (int c = 0; c < 8; c++) begin
      wr(1, IDX_TERMINATION, {26'h0, 3'(7 - c), 3'(c)});
      chk(tx_term_external[1], c[2], "tx ext");
      chk(tx_term_ohm_sel[3:2], c[1:0], "tx ohm");
      chk(rx_term_external[1], c[2] ^ 1'b1, "rx ext");
      chk(rx_term_ohm_sel[3:2], c[1:0] ^ 2'h3, "rx ohm");
      rdchk(1, IDX_TERMINATION, {26'h0, 3'(7 - c), 3'(c)}, "term read");
    end
    $display("test registers done");
  endtask : t_regs

  task automatic t_template();
    logic [3:0] tp [5] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h7};
    logic [1:0] ui [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
    logic [3:0] sp [5] = '{4'h0, 4'h0, 4'h9, 4'hF, 4'h0};
    logic [6:0] ex [5] = '{7'h1B, 7'h20, 7'h5F, 7'h43, 7'h00};
    // T1 internal termination both ways, used with T1 templates 3, 5, 6 and the J1 template 7
    wr(2, IDX_TERMINATION, 32'h12);
    chk(tx_term_external[2], 1'b0, "t1 internal");
    for (int i = 0; i < 5; i++) begin
      wr(2, IDX_TX_CONFIG_B, {28'h0, tp[i]});
      wave_ui     <= ui[i];
      wave_sample <= sp[i];
      repeat (3) @(posedge core_clk);
      chk(pulse_template_select[11:8], tp[i], "template");
      chk(wave_code[20:14], ex[i], "sample code");
    end
    wr(2, IDX_TX_CONFIG_B, 32'h0);
    $display("test template done");
  endtask : t_template

  task automatic t_tristate();
    wr(0, IDX_TX_CONFIG_B, 32'h10);
    repeat (4) @(posedge core_clk);
    chk(tx_line_oe, 4'hE, "chan tristate");
    line_driver_tristate <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(tx_line_oe, 4'h0, "global tristate");
    line_driver_tristate <= 1'b0;
    wr(0, IDX_TX_CONFIG_B, 32'h0);
    wr(2, IDX_TX_CONFIG_A, 32'h1);
    repeat (8) @(posedge core_clk);
    chk(tx_path_powered_down, 4'h4, "pwrdn");
    chk(tx_line_oe, 4'hB, "pwrdn oe");
    wr(2, IDX_TX_CONFIG_A, 32'h0);
    repeat (4) @(posedge core_clk);
    chk(tx_line_oe, 4'hF, "all drive");
    $display("test tristate done");
  endtask : t_tristate

  task automatic t_clkloss();
    mclk_run <= 1'b0;
    repeat (60) @(posedge core_clk);
    chk(tx_line_oe, 4'h0, "mclk lost");
    mclk_run <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk(tx_line_oe, 4'hF, "mclk back");
    wr(3, IDX_TX_CONFIG_A, 32'h2);
    wr(1, IDX_TX_CONFIG_A, 32'h4);
    tx_run <= 4'h0;
    repeat (60) @(posedge core_clk);
    chk(tx_line_oe, 4'hA, "txclk lost");
    tx_run <= 4'hF;
    repeat (20) @(posedge core_clk);
    chk(tx_line_oe, 4'hF, "txclk back");
    $display("test clock loss done");
  endtask : t_clkloss

  task automatic t_softreset();
    wr(0, IDX_SOFT_RESET, 32'h1);
    repeat (3) @(posedge core_clk);
    chk(tx_line_oe, 4'h0, "soft reset oe");
    rdchk(3, IDX_TX_CONFIG_A, 32'h0, "soft reset cfg");
    rdchk(0, IDX_AMP_SCALE, 32'h36, "soft reset scale");
    repeat (100) @(posedge core_clk);
    chk(tx_line_oe, 4'hF, "after soft hold");
    $display("test soft reset done");
  endtask : t_softreset

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // hang guard: the whole sequence needs well under 5000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_regs();
    t_template();
    t_tristate();
    t_clkloss();
    t_softreset();
    stop_test();
  end
endmodule : line_termination_driver_control_tb
